// ### design/perc_pkg.sv
// Constants, types and table layout for the particle event rate counters
package perc_pkg;
   localparam int NUM_START      = 6;
   localparam int SEC_W          = 3;
   localparam int E_W            = 10;
   localparam int T_W            = 6;
   localparam int BOX_W          = 3;
   localparam int NUM_BOX        = 8;
   localparam int NUM_CTYPE      = 3;
   localparam int RATES_PER_TYPE = NUM_BOX * NUM_START;
   localparam int NUM_RATE       = NUM_CTYPE * RATES_PER_TYPE;
   localparam int RIDX_W         = 8;
   localparam int TBL_AW         = 5;
   localparam int NUM_PIN        = NUM_START + 3;
   // Timing
   localparam int CLK_PERIOD_NS  = 10;
   localparam int CLK_HZ         = 100_000_000;
   localparam int TOF_MIN_NS     = 1;
   localparam int TOF_MAX_NS     = 320;
   localparam int TOF_MIN_CYC    = (TOF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TOF_MAX_CYC    = TOF_MAX_NS / CLK_PERIOD_NS;
   // Rate box table entry layout
   localparam int ENT_E_LO_LSB   = 0;
   localparam int ENT_E_HI_LSB   = 10;
   localparam int ENT_T_LO_LSB   = 20;
   localparam int ENT_T_HI_LSB   = 26;
   localparam int ENT_HMASK_LSB  = 32;
   localparam int ENT_HVAL_LSB   = 34;
   localparam int ENT_W          = 36;
   localparam logic [BOX_W-1:0] BOX_LAST = 3'h7;

   typedef enum logic [1:0] {
      PERC_ELECTRON              = 2'h0,
      PERC_ENERGY_AND_FLIGHT_ION = 2'h1,
      PERC_FLIGHT_ION            = 2'h2,
      PERC_DIAG                  = 2'h3
   } perc_type_e;

   typedef enum logic [4:0] {
      PERC_S_IDLE  = 5'h01,
      PERC_S_TIME  = 5'h02,
      PERC_S_LOOK  = 5'h04,
      PERC_S_CHECK = 5'h08,
      PERC_S_DONE  = 5'h10
   } perc_state_e;
endpackage : perc_pkg

// ### design/perc_tbl_mem.sv
// Rate box boundary table: one write port, one registered read port
`timescale 1ns/1ns
`default_nettype none
module perc_tbl_mem #(
   parameter int AW = 5,
   parameter int DW = 36
) (
   input  wire logic          clk,
   input  wire logic          ce,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [DW-1:0] wdata,
   input  wire logic [AW-1:0] raddr,
   output var  logic [DW-1:0] rdata
);
   logic [DW-1:0] mem [2**AW];

   always_ff @(posedge clk)
   begin
      if (ce)
      begin
         if (we)
            mem[waddr] <= wdata;
         rdata <= mem[raddr];
      end
   end
endmodule : perc_tbl_mem
`default_nettype wire

// ### design/perc_rate_counters.sv
// Valid-event logic: flight timing, event classification and rate counters
`timescale 1ns/1ns
`default_nettype none
module perc_rate_counters #(
   parameter int CNT_W   = 16,
   parameter int SEC_CYC = perc_pkg::CLK_HZ,
   parameter int KEEP_N  = 4
) (
   input  wire logic                           clk,
   input  wire logic                           reset,
   input  wire logic                           ce,
   input  wire logic [perc_pkg::NUM_START-1:0] start_pulse,
   input  wire logic                           stop_pulse,
   input  wire logic                           heavy_disc_first,
   input  wire logic                           heavy_disc_second,
   input  wire logic                           energy_valid,
   input  wire logic [perc_pkg::E_W-1:0]       energy_code,
   input  wire logic [perc_pkg::SEC_W-1:0]     energy_sector,
   input  wire logic                           cfg_diag_mode,
   input  wire logic [perc_pkg::NUM_START-1:0] cfg_start_enable,
   input  wire logic                           cfg_stop_enable,
   input  wire logic                           cfg_energy_enable,
   input  wire logic [perc_pkg::T_W-1:0]       cfg_window,
   input  wire logic                           cfg_multi_suppress,
   input  wire logic [15:0]                    cfg_short_sec,
   input  wire logic [7:0]                     cfg_long_mult,
   input  wire logic                           tbl_we,
   input  wire logic [perc_pkg::TBL_AW-1:0]    tbl_addr,
   input  wire logic [perc_pkg::ENT_W-1:0]     tbl_wdata,
   input  wire logic                           rd_long,
   input  wire logic [perc_pkg::RIDX_W-1:0]    rd_idx,
   output var  logic [CNT_W-1:0]               rd_data,
   output var  logic                           evt_valid,
   output var  logic                           evt_keep,
   output var  perc_pkg::perc_type_e           evt_type,
   output var  logic [perc_pkg::BOX_W-1:0]     evt_box,
   output var  logic [perc_pkg::SEC_W-1:0]     evt_sector,
   output var  logic [perc_pkg::T_W-1:0]       evt_tof,
   output var  logic [perc_pkg::E_W-1:0]       evt_energy,
   output var  logic                           evt_multi,
   output var  logic                           short_done,
   output var  logic                           long_done
);
   import perc_pkg::*;

   localparam logic [T_W-1:0] TOF_MIN = T_W'(TOF_MIN_CYC);
   localparam logic [T_W-1:0] TOF_MAX = T_W'(TOF_MAX_CYC);
   localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

   // Pin synchronisers; the first stage feeds only the second
   logic [NUM_PIN-1:0] pin_raw;
   logic [NUM_PIN-1:0] sync1_q;
   logic [NUM_PIN-1:0] sync2_q;
   logic [NUM_PIN-1:0] prev_q;
   assign pin_raw = {heavy_disc_second, heavy_disc_first, stop_pulse, start_pulse};
   genvar gp;
   generate
      for (gp = 0; gp < NUM_PIN; gp++)
      begin : g_sync
         always_ff @(posedge clk)
         begin
            if (reset)
            begin
               sync1_q[gp] <= 1'b0;
               sync2_q[gp] <= 1'b0;
               prev_q[gp]  <= 1'b0;
            end
            else if (ce)
            begin
               sync1_q[gp] <= pin_raw[gp];
               sync2_q[gp] <= sync1_q[gp];
               prev_q[gp]  <= sync2_q[gp];
            end
         end
      end
   endgenerate

   wire [NUM_START-1:0] start_rise = sync2_q[NUM_START-1:0] & ~prev_q[NUM_START-1:0]
                                     & cfg_start_enable;
   wire                 stop_rise  = sync2_q[NUM_START] & ~prev_q[NUM_START] & cfg_stop_enable;
   wire [1:0]           heavy_now  = sync2_q[NUM_START+2:NUM_START+1];
   wire                 e_evt      = energy_valid & cfg_energy_enable;

   // coincidence window, held inside the measurable flight range
   wire [T_W-1:0] win = (cfg_window > TOF_MAX) ? TOF_MAX :
                        (cfg_window < TOF_MIN) ? TOF_MIN : cfg_window;

   // lowest fired start segment names the direction
   function automatic logic [SEC_W-1:0] first_seg(input logic [NUM_START-1:0] v);
      logic [SEC_W-1:0] r;
      r = '0;
      for (int i = NUM_START - 1; i >= 0; i--)
         if (v[i])
            r = SEC_W'(i);
      return r;
   endfunction : first_seg

   perc_state_e          st_q, st_d;
   perc_type_e           type_q;
   logic [NUM_START-1:0] starts_q;
   logic [SEC_W-1:0]     sector_q;
   logic [T_W-1:0]       tof_q;
   logic [E_W-1:0]       energy_q;
   logic                 e_seen_q;
   logic [1:0]           heavy_q;
   logic [BOX_W-1:0]     box_q;
   logic                 hit_q;
   logic [ENT_W-1:0]     ent;

   perc_tbl_mem #(.AW(TBL_AW), .DW(ENT_W)) u_tbl (
      .clk   (clk),
      .ce    (ce),
      .we    (tbl_we),
      .waddr (tbl_addr),
      .wdata (tbl_wdata),
      .raddr ({type_q, box_q}),
      .rdata (ent)
   );

   wire e_in = (energy_q >= ent[ENT_E_LO_LSB +: E_W]) && (energy_q <= ent[ENT_E_HI_LSB +: E_W]);
   wire t_in = (tof_q >= ent[ENT_T_LO_LSB +: T_W]) && (tof_q <= ent[ENT_T_HI_LSB +: T_W]);
   wire h_ok = (heavy_q & ent[ENT_HMASK_LSB +: 2]) == ent[ENT_HVAL_LSB +: 2];
   logic box_match;
   always_comb
   begin
      case (type_q)
         PERC_ELECTRON:              box_match = e_in;
         PERC_ENERGY_AND_FLIGHT_ION: box_match = e_in & t_in;
         // flight range and heavy discriminator pattern
         PERC_FLIGHT_ION:            box_match = t_in & h_ok;
         default:                    box_match = 1'b0;
      endcase
   end

   wire multi     = (starts_q & (starts_q - NUM_START'(1))) != '0;
   wire timed_out = tof_q >= (win - T_W'(1));
   // flight event typed by presence of energy; diagnostic overrides
   wire perc_type_e stop_type = cfg_diag_mode ? PERC_DIAG :
                                e_seen_q ? PERC_ENERGY_AND_FLIGHT_ION : PERC_FLIGHT_ION;
   wire perc_type_e e_type    = cfg_diag_mode ? PERC_DIAG : PERC_ELECTRON;

   always_comb
   begin
      case (st_q)
         PERC_S_IDLE:  st_d = (|start_rise) ? PERC_S_TIME :
                              (!e_evt) ? PERC_S_IDLE :
                              cfg_diag_mode ? PERC_S_DONE : PERC_S_LOOK;
         PERC_S_TIME:  st_d = stop_rise ? ((stop_type == PERC_DIAG) ? PERC_S_DONE : PERC_S_LOOK) :
                              timed_out ? PERC_S_IDLE : PERC_S_TIME;
         PERC_S_LOOK:  st_d = PERC_S_CHECK;
         PERC_S_CHECK: st_d = (box_match || box_q == BOX_LAST) ? PERC_S_DONE : PERC_S_LOOK;
         PERC_S_DONE:  st_d = PERC_S_IDLE;
         default:      st_d = PERC_S_IDLE;
      endcase
   end

   // flight time counted in clock periods from start to stop
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         st_q     <= PERC_S_IDLE;
         type_q   <= PERC_ELECTRON;
         starts_q <= '0;
         sector_q <= '0;
         tof_q    <= '0;
         energy_q <= '0;
         e_seen_q <= 1'b0;
         heavy_q  <= 2'h0;
         box_q    <= '0;
         hit_q    <= 1'b0;
      end
      else if (ce)
      begin
         st_q <= st_d;
         case (st_q)
            PERC_S_IDLE:
            begin
               box_q <= '0;
               hit_q <= 1'b0;
               if (|start_rise)
               begin
                  starts_q <= start_rise;
                  sector_q <= first_seg(start_rise);
                  tof_q    <= TOF_MIN;
                  e_seen_q <= e_evt;
                  energy_q <= energy_code;
                  heavy_q  <= heavy_now;
               end
               else if (e_evt)
               begin
                  type_q   <= e_type;
                  sector_q <= energy_sector;
                  energy_q <= energy_code;
                  tof_q    <= '0;
                  starts_q <= '0;
                  heavy_q  <= 2'h0;
               end
            end
            PERC_S_TIME:
            begin
               tof_q    <= tof_q + T_W'(1);
               starts_q <= starts_q | start_rise;
               heavy_q  <= heavy_q | heavy_now;
               type_q   <= stop_type;
               if (e_evt)
               begin
                  e_seen_q <= 1'b1;
                  energy_q <= energy_code;
               end
            end
            PERC_S_CHECK:
               if (box_match)
                  hit_q <= 1'b1;
               else
                  box_q <= box_q + BOX_W'(1);
            default:
               hit_q <= hit_q;
         endcase
      end
   end

   // Interval timing: seconds, short intervals, long intervals
   logic [31:0] cyc_q;
   logic [15:0] sec_q;
   logic [7:0]  nshort_q;
   wire [15:0] short_len = (cfg_short_sec == 16'h0) ? 16'h1 : cfg_short_sec;
   wire [7:0]  long_len  = (cfg_long_mult == 8'h0) ? 8'h1 : cfg_long_mult;
   wire        sec_tick  = cyc_q == 32'(SEC_CYC - 1);
   wire        short_end = sec_tick && (sec_q == short_len - 16'h1);
   // long interval is a whole number of short intervals
   wire        long_end  = short_end && (nshort_q == long_len - 8'h1);

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         cyc_q    <= '0;
         sec_q    <= '0;
         nshort_q <= '0;
      end
      else if (ce)
      begin
         cyc_q    <= sec_tick ? 32'h0 : cyc_q + 32'h1;
         sec_q    <= short_end ? 16'h0 : (sec_tick ? sec_q + 16'h1 : sec_q);
         nshort_q <= long_end ? 8'h0 : (short_end ? nshort_q + 8'h1 : nshort_q);
      end
   end

   // rate index from type, box and sector; multi-hit suppression
   wire cnt_en = (st_q == PERC_S_DONE) && hit_q && (type_q != PERC_DIAG)
                 && !(multi && cfg_multi_suppress);
   wire [RIDX_W-1:0] cnt_idx = RIDX_W'(type_q) * RIDX_W'(RATES_PER_TYPE)
                               + RIDX_W'(box_q) * RIDX_W'(NUM_START) + RIDX_W'(sector_q);

   logic [CNT_W-1:0] short_cnt_q [NUM_RATE];
   logic [CNT_W-1:0] long_cnt_q  [NUM_RATE];
   logic [CNT_W-1:0] short_snap_q[NUM_RATE];
   logic [CNT_W-1:0] long_snap_q [NUM_RATE];
   genvar gr;
   generate
      for (gr = 0; gr < NUM_RATE; gr++)
      begin : g_rate
         wire hit = cnt_en && (cnt_idx == RIDX_W'(gr));
         // both counters step together; an event on a boundary opens the new interval
         always_ff @(posedge clk)
         begin
            if (reset)
            begin
               short_cnt_q[gr]  <= '0;
               long_cnt_q[gr]   <= '0;
               short_snap_q[gr] <= '0;
               long_snap_q[gr]  <= '0;
            end
            else if (ce)
            begin
               if (short_end)
                  short_snap_q[gr] <= short_cnt_q[gr];
               if (long_end)
                  long_snap_q[gr] <= long_cnt_q[gr];
               short_cnt_q[gr] <= short_end ? CNT_W'(hit) :
                                  (hit && short_cnt_q[gr] != CNT_MAX) ? short_cnt_q[gr] + CNT_W'(1)
                                  : short_cnt_q[gr];
               long_cnt_q[gr]  <= long_end ? CNT_W'(hit) :
                                  (hit && long_cnt_q[gr] != CNT_MAX) ? long_cnt_q[gr] + CNT_W'(1)
                                  : long_cnt_q[gr];
            end
         end
      end
   endgenerate

   // first KEEP_N records of each type per short interval are retained
   logic [7:0] kept_q [4];
   wire keep_now = short_end || (kept_q[type_q] < 8'(KEEP_N));
   // snapshots stay stable for one full interval
   wire rd_ok = rd_idx < RIDX_W'(NUM_RATE);
   wire [CNT_W-1:0] rd_mux = !rd_ok ? '0 : (rd_long ? long_snap_q[rd_idx] : short_snap_q[rd_idx]);

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         kept_q     <= '{default: 8'h0};
         rd_data    <= '0;
         evt_valid  <= 1'b0;
         evt_keep   <= 1'b0;
         evt_type   <= PERC_ELECTRON;
         evt_box    <= '0;
         evt_sector <= '0;
         evt_tof    <= '0;
         evt_energy <= '0;
         evt_multi  <= 1'b0;
         short_done <= 1'b0;
         long_done  <= 1'b0;
      end
      else if (ce)
      begin
         rd_data    <= rd_mux;
         short_done <= short_end;
         long_done  <= long_end;
         // one record per event, held until the next
         evt_valid  <= st_q == PERC_S_DONE;
         if (st_q == PERC_S_DONE)
         begin
            evt_keep   <= keep_now;
            evt_type   <= type_q;
            evt_box    <= hit_q ? box_q : '0;
            evt_sector <= sector_q;
            evt_tof    <= tof_q;
            evt_energy <= energy_q;
            evt_multi  <= multi;
         end
         if (short_end)
            kept_q <= '{default: 8'h0};
         if (st_q == PERC_S_DONE && keep_now)
            kept_q[type_q] <= short_end ? 8'h1 : kept_q[type_q] + 8'h1;
      end
   end
endmodule : perc_rate_counters
`default_nettype wire

// ### tb/perc_rate_counters_props.sv
// Port-level assertions for the rate counter block
`timescale 1ns/1ns
`default_nettype none
module perc_rate_counters_props #(
   parameter int CNT_W   = 16,
   parameter int SEC_CYC = 100
) (
   input wire logic                         clk,
   input wire logic                         reset,
   input wire logic                         cfg_diag_mode,
   input wire logic [15:0]                  cfg_short_sec,
   input wire logic [7:0]                   cfg_long_mult,
   input wire logic [perc_pkg::RIDX_W-1:0]  rd_idx,
   input wire logic [CNT_W-1:0]             rd_data,
   input wire logic                         evt_valid,
   input wire logic                         evt_keep,
   input wire perc_pkg::perc_type_e         evt_type,
   input wire logic [perc_pkg::BOX_W-1:0]   evt_box,
   input wire logic [perc_pkg::SEC_W-1:0]   evt_sector,
   input wire logic [perc_pkg::T_W-1:0]     evt_tof,
   input wire logic [perc_pkg::E_W-1:0]     evt_energy,
   input wire logic                         evt_multi,
   input wire logic                         short_done,
   input wire logic                         long_done
);
   import perc_pkg::*;
   logic [31:0] gap_q;
   logic        seen_q;
   logic [7:0]  nshort_q;
   logic [31:0] short_len;
   // Assumes cfg_short_sec held steady
   assign short_len = 32'(cfg_short_sec) * 32'(SEC_CYC);
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         gap_q    <= 32'h0;
         seen_q   <= 1'b0;
         nshort_q <= 8'h0;
      end
      else
      begin
         gap_q    <= short_done ? 32'h0 : gap_q + 32'h1;
         seen_q   <= seen_q | short_done;
         nshort_q <= long_done ? 8'h0 : nshort_q + {7'h0, short_done};
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   a_evt_one_pulse: assert property (evt_valid |=> !evt_valid)
      else $error("evt_valid held longer than one cycle");
   a_diag_type_set: assert property (evt_valid && cfg_diag_mode |-> evt_type == PERC_DIAG)
      else $error("record in diagnostic mode not typed diagnostic");
   a_normal_type_ok: assert property (evt_valid && !cfg_diag_mode |-> evt_type != PERC_DIAG)
      else $error("record in normal mode typed diagnostic");
   a_sector_in_range: assert property (evt_valid |-> evt_sector < 3'h6)
      else $error("record sector out of range");
   a_fields_hold: assert property (!evt_valid |->
      $stable({evt_type, evt_box, evt_sector, evt_tof, evt_energy, evt_multi, evt_keep}))
      else $error("record fields changed without evt_valid");
   a_tof_in_range: assert property (evt_valid && (evt_type == PERC_FLIGHT_ION ||
      evt_type == PERC_ENERGY_AND_FLIGHT_ION) |->
      evt_tof >= 6'(TOF_MIN_CYC) && evt_tof <= 6'(TOF_MAX_CYC))
      else $error("flight time outside measurable range");
   a_short_period: assert property (short_done && seen_q |-> gap_q == short_len - 32'h1)
      else $error("short interval length wrong");
   a_short_one_pulse: assert property (short_done |=> !short_done [*8])
      else $error("short_done too soon");
   a_long_period: assert property (long_done |->
      short_done && nshort_q == cfg_long_mult - 8'h1)
      else $error("long interval not a whole number of short intervals");
   a_unmapped_zero: assert property (rd_idx >= 8'h90 |=> rd_data == '0)
      else $error("read beyond last rate not zero");
endmodule : perc_rate_counters_props
bind perc_rate_counters perc_rate_counters_props #(.CNT_W(CNT_W), .SEC_CYC(SEC_CYC)) u_props (
   .clk(clk), .reset(reset), .cfg_diag_mode(cfg_diag_mode), .cfg_short_sec(cfg_short_sec),
   .cfg_long_mult(cfg_long_mult), .rd_idx(rd_idx), .rd_data(rd_data), .evt_valid(evt_valid),
   .evt_keep(evt_keep), .evt_type(evt_type), .evt_box(evt_box), .evt_sector(evt_sector),
   .evt_tof(evt_tof), .evt_energy(evt_energy), .evt_multi(evt_multi),
   .short_done(short_done), .long_done(long_done));
`default_nettype wire

// ### tb/perc_host_model.sv
// Processor model that sweeps every snapshot after each interval boundary
`timescale 1ns/1ns
`default_nettype none
module perc_host_model (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       short_done,
   input  wire logic       long_done,
   output var  logic       rd_long,
   output var  logic [7:0] rd_idx,
   output var  logic       snap_valid,
   output var  logic       snap_long,
   output var  logic [7:0] snap_idx
);
   logic busy_q;
   logic pend_q;
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         {busy_q, pend_q, rd_long, rd_idx, snap_valid, snap_long, snap_idx} <= '0;
      end
      else
      begin
         snap_valid <= busy_q;
         snap_long  <= rd_long;
         snap_idx   <= rd_idx;
         if (long_done)
            pend_q <= 1'b1;
         if (busy_q)
         begin
            // Sweep runs one past the last rate so the unmapped read is exercised
            busy_q <= (rd_idx != 8'h90);
            rd_idx <= rd_idx + 8'h1;
         end
         else if (short_done | pend_q)
         begin
            busy_q  <= 1'b1;
            rd_long <= ~short_done;
            rd_idx  <= 8'h0;
            if (!short_done)
               pend_q <= 1'b0;
         end
      end
   end
endmodule : perc_host_model
`default_nettype wire

// ### tb/perc_rate_counters_test.sv
// Self-checking bench for the particle event rate counters
`timescale 1ns/1ns
`default_nettype none
module perc_rate_counters_test;
   import perc_pkg::*;
   localparam int SEC  = 100;
   localparam int KEEP = 4;
   logic clk = 1'b0, reset = 1'b1, stop_pulse = 1'b0, energy_valid = 1'b0;
   logic heavy_disc_first = 1'b0, heavy_disc_second = 1'b0, tbl_we = 1'b0;
   logic cfg_diag_mode = 1'b0, cfg_stop_enable = 1'b1, cfg_energy_enable = 1'b1;
   logic cfg_multi_suppress = 1'b1;
   logic [5:0] start_pulse = 6'h0, cfg_start_enable = 6'h3f, cfg_window = 6'h14;
   logic [9:0] energy_code = 10'h0;
   logic [2:0] energy_sector = 3'h0;
   logic [15:0] cfg_short_sec = 16'h4;
   logic [7:0] cfg_long_mult = 8'h2;
   logic [4:0] tbl_addr = 5'h0;
   logic [ENT_W-1:0] tbl_wdata = '0;
   wire logic rd_long, evt_valid, evt_keep, evt_multi, short_done, long_done;
   wire logic snap_valid, snap_long;
   wire logic [7:0] rd_idx, snap_idx;
   wire logic [15:0] rd_data;
   wire perc_type_e evt_type;
   wire logic [2:0] evt_box, evt_sector;
   wire logic [5:0] evt_tof;
   wire logic [9:0] evt_energy;
   int err_count = 0, compares = 0, seed, i, cur_idx, cur_type;
   int acc_s[145], acc_l[145], exp_s[145], exp_l[145], kept[4];
   logic cur_cnt, pend = 1'b0;
   always #5 clk = ~clk;
   perc_rate_counters #(.SEC_CYC(SEC), .KEEP_N(KEEP)) u_perc_rate_counters (
      .clk(clk), .reset(reset), .ce(1'b1), .start_pulse(start_pulse), .stop_pulse(stop_pulse),
      .heavy_disc_first(heavy_disc_first), .heavy_disc_second(heavy_disc_second),
      .energy_valid(energy_valid), .energy_code(energy_code), .energy_sector(energy_sector),
      .cfg_diag_mode(cfg_diag_mode), .cfg_start_enable(cfg_start_enable),
      .cfg_stop_enable(cfg_stop_enable), .cfg_energy_enable(cfg_energy_enable),
      .cfg_window(cfg_window), .cfg_multi_suppress(cfg_multi_suppress),
      .cfg_short_sec(cfg_short_sec), .cfg_long_mult(cfg_long_mult), .tbl_we(tbl_we),
      .tbl_addr(tbl_addr), .tbl_wdata(tbl_wdata), .rd_long(rd_long), .rd_idx(rd_idx),
      .rd_data(rd_data), .evt_valid(evt_valid), .evt_keep(evt_keep), .evt_type(evt_type),
      .evt_box(evt_box), .evt_sector(evt_sector), .evt_tof(evt_tof), .evt_energy(evt_energy),
      .evt_multi(evt_multi), .short_done(short_done), .long_done(long_done));
   perc_host_model u_perc_host_model (
      .clk(clk), .reset(reset), .short_done(short_done), .long_done(long_done),
      .rd_long(rd_long), .rd_idx(rd_idx), .snap_valid(snap_valid), .snap_long(snap_long),
      .snap_idx(snap_idx));
   task automatic stop_test;
      $display("Checks made %0d, mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : stop_test
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      compares++;
      if (got !== ex)
      begin
         err_count++;
         $display("MISMATCH %s expected %0h seen %0h", nm, ex, got);
      end
   endtask : chk
   // Boxes tile the planes with no overlap, so the first match is the only match
   function automatic logic [ENT_W-1:0] ent(input int a);
      int b;
      logic [9:0] el, eh;
      logic [5:0] tl, th;
      logic [1:0] m, v;
      b = a % 8;
      el = 10'h0;
      eh = (a < 24) ? 10'h3ff : 10'h0;
      tl = (b >= 4 && a >= 8) ? 6'ha : 6'h0;
      th = (b < 4 && a >= 8) ? 6'h9 : 6'h3f;
      m = (a / 8 == 2) ? 2'h3 : 2'h0;
      v = 2'(b % 4);
      if (a < 8)
      begin
         el = 10'(b * 128);
         eh = 10'(b * 128 + 127);
      end
      else if (a < 16)
      begin
         el = 10'((b % 4) * 256);
         eh = 10'((b % 4) * 256 + 255);
      end
      return {v, m, th, tl, eh, el};
   endfunction : ent
   function automatic int exp_box(input int k, input logic [9:0] e, input logic [1:0] h,
                                  input int t);
      if (k == 0)
         return int'(e[9:7]);
      return ((t >= 10) ? 4 : 0) + ((k == 1) ? int'(e[9:8]) : int'(h));
   endfunction : exp_box
   // One event: kind 0 electron, 1 energy and flight ion, 2 flight-only ion
   task automatic ev(input int k, input int s, input int s2, input int t, input logic want);
      logic [9:0] e;
      logic [1:0] h;
      int bx, n;
      e = 10'($random(seed));
      h = 2'($random(seed));
      bx = exp_box(k, e, h, t);
      cur_type = cfg_diag_mode ? 3 : k;
      cur_idx = k * 48 + bx * 6 + s;
      cur_cnt = !cfg_diag_mode && !(s2 >= 0 && k != 0 && cfg_multi_suppress);
      energy_code = e;
      energy_sector = 3'(s);
      if (k == 0)
         energy_valid = 1'b1;
      else
         start_pulse[s] = 1'b1;
      {heavy_disc_second, heavy_disc_first} = (k == 0) ? 2'h0 : h;
      for (n = 1; n <= ((k == 0) ? 1 : t + 2); n++)
      begin
         @(posedge clk);
         #1;
         if (n == 2 && s2 >= 0)
            start_pulse[s2] = 1'b1;
         energy_valid = (k == 1 && n == 4);
         if (n == t)
            stop_pulse = 1'b1;
      end
      start_pulse = 6'h0;
      stop_pulse = 1'b0;
      {heavy_disc_second, heavy_disc_first} = 2'h0;
      n = 0;
      while (n < 50 && evt_valid !== 1'b1)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      chk("evt_valid", want, evt_valid === 1'b1);
      if (want && n == 50)
         stop_test();
      if (want)
      begin
         chk("evt_type", cur_type, evt_type);
         chk("evt_sector", s, evt_sector);
         if (!cfg_diag_mode)
         begin
            chk("evt_box", bx, evt_box);
            chk("evt_multi", s2 >= 0 && k != 0, evt_multi);
            if (k != 0)
               chk("evt_tof", 1, evt_tof >= t - 1 && evt_tof <= t + 1);
            if (k != 2)
               chk("evt_energy", e, evt_energy);
         end
      end
      repeat (4) @(posedge clk);
      #1;
   endtask : ev
   task automatic wait_for(input logic lng);
      int n;
      n = 0;
      while (n < 2000 && (lng ? long_done : short_done) !== 1'b1)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n == 2000)
      begin
         err_count++;
         stop_test();
      end
   endtask : wait_for
   // An event counted at the snapshot edge belongs to the new interval, hence pend
   always @(posedge clk)
   begin
      if (pend)
      begin
         acc_s[cur_idx] += int'(cur_cnt);
         acc_l[cur_idx] += int'(cur_cnt);
         chk("evt_keep", kept[cur_type] < KEEP, evt_keep);
         kept[cur_type]++;
      end
      if (short_done === 1'b1)
      begin
         exp_s = acc_s;
         acc_s = '{default: 0};
         kept = '{default: 0};
      end
      if (long_done === 1'b1)
      begin
         exp_l = acc_l;
         acc_l = '{default: 0};
      end
      pend = (evt_valid === 1'b1);
      if (snap_valid === 1'b1)
         chk("rd_data", snap_long ? exp_l[snap_idx] : exp_s[snap_idx], rd_data);
   end
   initial
   begin
      seed = 32'h75c6;
      repeat (6) @(posedge clk);
      #1;
      reset = 1'b0;
      for (i = 0; i < 32; i++)
      begin
         tbl_we = 1'b1;
         tbl_addr = 5'(i);
         tbl_wdata = ent(i);
         @(posedge clk);
         #1;
      end
      tbl_we = 1'b0;
      for (i = 0; i < 60; i++)
      begin
         cfg_multi_suppress = 1'($random(seed));
         cur_type = {$random(seed)} % 6;
         ev({$random(seed)} % 3, cur_type, ({$random(seed)} % 3 == 0 && cur_type < 5) ?
            cur_type + 1 : -1, ({$random(seed)} % 2 == 1) ? 14 : 6, 1'b1);
      end
      $display("Test random traffic done");
      ev(1, 2, -1, 25, 1'b0);
      cfg_start_enable = 6'h3e;
      ev(2, 0, -1, 6, 1'b0);
      cfg_start_enable = 6'h3f;
      cfg_energy_enable = 1'b0;
      ev(0, 3, -1, 6, 1'b0);
      cfg_energy_enable = 1'b1;
      cfg_stop_enable = 1'b0;
      ev(2, 1, -1, 6, 1'b0);
      cfg_stop_enable = 1'b1;
      cfg_diag_mode = 1'b1;
      ev(0, 4, -1, 6, 1'b1);
      ev(2, 5, -1, 14, 1'b1);
      cfg_diag_mode = 1'b0;
      cfg_multi_suppress = 1'b1;
      ev(1, 1, 3, 14, 1'b1);
      cfg_multi_suppress = 1'b0;
      ev(2, 4, 5, 6, 1'b1);
      $display("Test corner cases done");
      wait_for(1'b1);
      @(posedge clk);
      #1;
      wait_for(1'b0);
      $display("Test final readout done");
      stop_test();
   end
endmodule : perc_rate_counters_test
`default_nettype wire
